// ### rtl/phyls_pkg.sv
// constants, field layouts and carrier types for the phy lock and analog register bank
package phyls_pkg;

  // timing: one second of receive up time counted in status clock cycles
  localparam int CLK_PERIOD_NS = 40;
  localparam int SECOND_NS     = 1000000000;
  localparam int SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ANALOG_SET  = 8'h07;
  localparam logic [7:0] IDX_ANALOG_RB   = 8'h09;
  localparam logic [7:0] IDX_LOCK_STAT   = 8'h10;
  localparam logic [7:0] IDX_UPTIME      = 8'h11;
  localparam logic [7:0] IDX_BLOCK_SYNC  = 8'h12;
  localparam logic [7:0] IDX_MARKER_LOCK = 8'h13;
  localparam logic [7:0] IDX_RX_SUMMARY  = 8'h14;

  // lane_analog_settings control word layout
  localparam int CTRL_LOOPBACK_BIT = 31;
  localparam int CTRL_RD_BIT       = 30;
  localparam int CTRL_WR_BIT       = 29;
  localparam int CTRL_SET_HI       = 28;
  localparam int CTRL_SET_LO       = 4;
  localparam int CTRL_CH_HI        = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // analog_readback layout
  localparam int RB_VALID_BIT = 25;
  localparam logic [25:0] RB_RST = 26'h002_0080;

  // channel counts
  localparam int NUM_LCH = 10;
  localparam int NUM_PCH = 20;

  // rx_link_summary bit positions
  localparam int SUM_PERM_CHG_BIT = 4;
  localparam int SUM_DESKEW_CHG_BIT = 3;
  localparam int SUM_TAG_CHG_BIT  = 2;
  localparam int SUM_NORMAL_BIT   = 1;
  localparam int SUM_ALL_LOCK_BIT = 0;

  // reserved ones in pll_cdr_lock_status for each variant
  localparam logic [31:0] LOCK_RSV_100G  = 32'hFE3F_F000;
  localparam logic [31:0] LOCK_RSV_40G   = 32'hFFFF_FF80;
  localparam logic [31:0] LOCK_RSV_CAUI4 = 32'hFC3F_FFC0;

  typedef enum {PHYLS_40G, PHYLS_100G, PHYLS_CAUI4} phyls_variant_t;

  // per channel analog settings, same order as control bits 28:4
  typedef struct packed {
    logic [3:0] eq_ctrl;
    logic [2:0] dc_gain;
    logic [4:0] tap0;
    logic [4:0] tap1;
    logic [4:0] tap2;
    logic [2:0] amplitude;
  } phyls_analog_t;

  localparam phyls_analog_t ANALOG_RST = '{eq_ctrl: 4'h3, dc_gain: 3'h0, tap0: 5'h10,
                                           tap1: 5'h00, tap2: 5'h10, amplitude: 3'h2};

  // status reported by the pcs and transceivers
  typedef struct packed {
    logic [3:0]         tx_pll_lock;
    logic [9:0]         rx_cdr_lock;
    logic               tx_ready;
    logic               rx_ready;
    logic [NUM_PCH-1:0] block_lock;
    logic [NUM_PCH-1:0] marker_lock;
    logic               lanes_deskewed;
    logic               mapping_chg;
    logic               tag_drop_chg;
  } phyls_pcs_status_t;

endpackage : phyls_pkg

// ### rtl/phyls_regs.sv
// phy lock status and per channel analog settings register bank on ahb-lite
`timescale 1ns/1ns
// Contract
// - equalizer field 28:25, resets to 0011
// - dc gain 3 dB steps, resets zero
// - tap zero pre-emphasis, resets 10000
// - tap one pre-emphasis, resets zero
// - tap two 10000, amplitude resets 010
// - 100G lock layout, reserved reads ones
// - 40G lock layout, reserved reads ones
// - four-lane layout, reserved reads ones
// - bits 1,0 interface ready, reset low
// - seconds of continuous up, wraps
// - per channel block boundary lock
// - per channel alignment marker lock
// - mapping change flag, clear on read
// - deskew change flag, clear on read
// - tag drop change flag, clear on read
// - normal when all locked and deskewed
// - all lanes block and marker locked
// - channel select, strobe acts next edge
// - readback holds settings, valid bit 25
module phyls_regs
  import phyls_pkg::*;
#(
  parameter phyls_variant_t VARIANT    = PHYLS_100G,
  parameter int             SEC_CYCLES_P = SEC_CYCLES
) (
  input  wire logic              mclk,        // status clock, 25 MHz
  input  wire logic              reset_n,     // async reset, active low
  input  wire logic              hsel,        // ahb slave select
  input  wire logic [11:0]       haddr,       // ahb byte address
  input  wire logic [1:0]        htrans,      // ahb transfer type
  input  wire logic              hwrite,      // ahb write
  input  wire logic [2:0]        hsize,       // ahb size, word only
  input  wire logic [31:0]       hwdata,      // ahb write data
  input  wire logic              hready,      // ahb bus ready
  output logic                   hreadyout,   // always ready
  output logic                   hresp,       // always okay
  output logic [31:0]            hrdata,      // registered read data
  input  wire phyls_pcs_status_t pcs_status,  // pcs and transceiver status
  output phyls_analog_t          analog_cfg [NUM_LCH], // settings per logical channel
  output logic                   serial_loopback // tx to rx loopback enable
);

  // bus phase tracking
  logic        wr_pend_q;
  logic [7:0]  wr_idx_q;
  logic [31:0] rdata_q;

  // register state
  logic [31:0]        ctrl_q;
  logic [31:0]        ctrl_d;
  logic               rd_prev_q;
  logic               wr_prev_q;
  logic [25:0]        rb_q;
  logic [25:0]        rb_d;
  phyls_analog_t      set_q [NUM_LCH];
  phyls_pcs_status_t  st_q;
  logic               deskew_prev_q;
  logic [2:0]         flag_q;
  logic [2:0]         flag_d;
  logic [31:0]        cyc_q;
  logic [31:0]        cyc_d;
  logic [31:0]        sec_q;
  logic [31:0]        sec_d;

  // address phase decode
  wire         xfer_ok   = hsel & htrans[1] & hready;
  wire         rd_take   = xfer_ok & ~hwrite;
  wire         wr_take   = xfer_ok & hwrite;
  wire [7:0]   addr_idx  = haddr[9:2];
  wire         sum_read  = rd_take & (addr_idx == IDX_RX_SUMMARY);
  wire         ctrl_wr   = wr_pend_q & (wr_idx_q == IDX_ANALOG_SET);

  // analog strobes act on their rising bit, one edge after software sets them
  wire         rd_rise   = ctrl_q[CTRL_RD_BIT] & ~rd_prev_q;
  wire         wr_rise   = ctrl_q[CTRL_WR_BIT] & ~wr_prev_q;
  wire [3:0]   sel_ch    = ctrl_q[CTRL_CH_HI:0];
  wire         ch_ok     = sel_ch < 4'(NUM_LCH);
  wire phyls_analog_t new_set = ctrl_q[CTRL_SET_HI:CTRL_SET_LO];

  // summary status from the registered pcs status
  wire         all_lock  = (&st_q.block_lock) & (&st_q.marker_lock);
  wire         normal    = all_lock & st_q.lanes_deskewed;
  wire         deskew_chg = st_q.lanes_deskewed ^ deskew_prev_q;
  wire [2:0]   flag_set  = {st_q.mapping_chg, deskew_chg, st_q.tag_drop_chg};
  wire [31:0]  summary   = {27'h0, flag_q, normal, all_lock};

  // lock word assembly; reserved fields read as ones
  function automatic logic [31:0] lock_word(phyls_pcs_status_t s);
    logic [31:0] w;
    w = 32'h0;
    unique case (VARIANT)
      PHYLS_100G: begin
        w = LOCK_RSV_100G;
        w[24:22] = s.tx_pll_lock[2:0];
        w[11:2]  = s.rx_cdr_lock;
      end
      PHYLS_40G: begin
        w = LOCK_RSV_40G;
        w[6]   = s.tx_pll_lock[0];
        w[5:2] = s.rx_cdr_lock[3:0];
      end
      PHYLS_CAUI4: begin
        w = LOCK_RSV_CAUI4;
        w[25:22] = s.tx_pll_lock;
        w[5:2]   = s.rx_cdr_lock[3:0];
      end
    endcase
    w[1] = s.tx_ready;
    w[0] = s.rx_ready;
    return w;
  endfunction : lock_word

  wire [31:0] lock_val = lock_word(st_q);

  // read mux; unmapped addresses read zero
  wire [31:0] rd_mux =
      (addr_idx == IDX_ANALOG_SET)  ? ctrl_q :
      (addr_idx == IDX_ANALOG_RB)   ? {6'h00, rb_q} :
      (addr_idx == IDX_LOCK_STAT)   ? lock_val :
      (addr_idx == IDX_UPTIME)      ? sec_q :
      (addr_idx == IDX_BLOCK_SYNC)  ? {12'h000, st_q.block_lock} :
      (addr_idx == IDX_MARKER_LOCK) ? {12'h000, st_q.marker_lock} :
      (addr_idx == IDX_RX_SUMMARY)  ? summary : 32'h0000_0000;

  // zero wait states, so the bus always sees ready and okay
  assign hreadyout       = 1'h1;
  assign hresp           = 1'h0;
  assign hrdata          = rdata_q;
  assign analog_cfg      = set_q;
  assign serial_loopback = ctrl_q[CTRL_LOOPBACK_BIT];

  // control word takes the data phase of a write
  assign ctrl_d = ctrl_wr ? hwdata : ctrl_q;

  // readback: settings of the selected channel, or the reset defaults for an out of range channel, land together with valid set
  assign rb_d = rd_rise ? {1'h1, (ch_ok ? set_q[sel_ch] : ANALOG_RST)} : rb_q;

  // set beats clear so an event during the read is not lost
  assign flag_d = flag_set | (flag_q & ~{3{sum_read}});

  // up time: restarts when the receiver leaves normal operation
  assign cyc_d = !normal ? 32'h0 :
                 (cyc_q == 32'(SEC_CYCLES_P - 1)) ? 32'h0 : cyc_q + 32'h1;
  assign sec_d = !normal ? 32'h0 :
                 (cyc_q == 32'(SEC_CYCLES_P - 1)) ? sec_q + 32'h1 : sec_q;

  // bus phase registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_q <= 1'h0;
      wr_idx_q  <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_take;
      wr_idx_q  <= addr_idx;
      rdata_q   <= rd_take ? rd_mux : rdata_q;
    end
  end

  // control and readback registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q    <= CTRL_RST;
      rd_prev_q <= 1'h0;
      wr_prev_q <= 1'h0;
      rb_q      <= RB_RST;
    end else begin
      ctrl_q    <= ctrl_d;
      rd_prev_q <= ctrl_q[CTRL_RD_BIT];
      wr_prev_q <= ctrl_q[CTRL_WR_BIT];
      rb_q      <= rb_d;
    end
  end

  // per channel settings store; out of range channels are ignored
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_LCH; i++) begin
        set_q[i] <= ANALOG_RST;
      end
    end else if (wr_rise && ch_ok) begin
      set_q[sel_ch] <= new_set;
    end
  end

  // status capture, change flags and up time counter
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q          <= '0;
      deskew_prev_q <= 1'h0;
      flag_q        <= 3'h0;
      cyc_q         <= 32'h0000_0000;
      sec_q         <= 32'h0000_0000;
    end else begin
      st_q          <= pcs_status;
      deskew_prev_q <= st_q.lanes_deskewed;
      flag_q        <= flag_d;
      cyc_q         <= cyc_d;
      sec_q         <= sec_d;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  analog_reset_a: assert property ($rose(reset_n) |-> set_q[0] == ANALOG_RST &&
      rb_q == RB_RST)
    else $error("analog settings not at reset defaults");

  eq_default_a: assert property ($rose(reset_n) |-> set_q[NUM_LCH-1].eq_ctrl == 4'h3 &&
      set_q[NUM_LCH-1].dc_gain == 3'h0 && set_q[NUM_LCH-1].tap1 == 5'h00)
    else $error("equalizer gain or tap one default wrong");

  tap_default_a: assert property ($rose(reset_n) |-> set_q[1].tap0 == 5'h10 &&
      set_q[1].tap2 == 5'h10 && set_q[1].amplitude == 3'h2)
    else $error("tap zero tap two or amplitude default wrong");

  strobe_write_a: assert property (ctrl_wr && hwdata[CTRL_WR_BIT] && !ctrl_q[CTRL_WR_BIT] &&
      hwdata[CTRL_CH_HI:0] == 4'h2 |-> ##2 set_q[2] == $past(hwdata[CTRL_SET_HI:CTRL_SET_LO], 2))
    else $error("channel settings not written two edges after strobe");

  readback_a: assert property (rd_rise && ch_ok |=> rb_q[RB_VALID_BIT] &&
      rb_q[24:0] == $past(set_q[sel_ch]))
    else $error("readback does not hold selected channel settings");

  lock_rsv_a: assert property (1'h1 |-> ((VARIANT == PHYLS_100G) ?
      (lock_val & LOCK_RSV_100G) == LOCK_RSV_100G : (VARIANT == PHYLS_40G) ?
      (lock_val & LOCK_RSV_40G) == LOCK_RSV_40G :
      (lock_val & LOCK_RSV_CAUI4) == LOCK_RSV_CAUI4))
    else $error("reserved lock bits not all ones");

  ready_bits_a: assert property (##1 lock_val[1:0] == $past({pcs_status.tx_ready,
      pcs_status.rx_ready}))
    else $error("interface ready bits do not follow status");

  uptime_a: assert property (normal && cyc_q == 32'(SEC_CYCLES_P - 1) && $past(normal)
      |=> sec_q == $past(sec_q) + 32'h1)
    else $error("up time second count did not advance");

  uptime_drop_a: assert property (!normal |=> sec_q == 32'h0 && cyc_q == 32'h0)
    else $error("up time not restarted on loss of normal operation");

  flag_keep_a: assert property (sum_read && st_q.mapping_chg |=> flag_q[2])
    else $error("mapping change lost during summary read");

  flag_clear_a: assert property (sum_read && flag_set == 3'h0 |=> flag_q == 3'h0)
    else $error("change flags not cleared by summary read");

  // expected lock summary rebuilt from the pcs inputs one edge back
  summary_a: assert property (##1 (summary[SUM_ALL_LOCK_BIT] ==
      ((&$past(pcs_status.block_lock)) && (&$past(pcs_status.marker_lock)))) &&
      (!summary[SUM_NORMAL_BIT] || summary[SUM_ALL_LOCK_BIT]))
    else $error("summary lock bits inconsistent");

  cover_read_valid: cover property (rd_rise ##1 rb_q[RB_VALID_BIT]);
  cover_flag_cor:   cover property (flag_q[1] ##1 sum_read ##1 !flag_q[1]);
  cover_one_second: cover property (normal && sec_q == 32'h1);

endmodule : phyls_regs

// ### testbench/tb_top.sv
// self-checking bench for the phy lock status and analog settings register bank
`timescale 1ns/1ns
module tb_top
  import phyls_pkg::*;
;
  logic              mclk;
  logic              reset_n;
  logic              hsel;
  logic [11:0]       haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [2:0]        hsize;
  logic [31:0]       hwdata;
  wire logic         hready;
  wire logic         hresp;
  wire logic [31:0]  hrdata;
  phyls_pcs_status_t pcs;
  phyls_analog_t     cfg [NUM_LCH];
  wire logic         serial_loopback;
  int                miscompares;
  int                n_tests;
  logic [31:0]       rd;
  logic [24:0]       sv;
  logic [3:0]        ch;
  int                chs [3] = '{2, 9, 12};
  phyls_analog_t     tune;

  // short second so the up time counter moves within the run
  phyls_regs #(.VARIANT(PHYLS_100G), .SEC_CYCLES_P(10)) u_phyls_regs (
    .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .pcs_status(pcs), .analog_cfg(cfg),
    .serial_loopback(serial_loopback));

  // 25 MHz status clock
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one single ahb-lite transfer; never assumes a wait-state count
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rdat);
    hsel   <= 1'b1;
    haddr  <= {2'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rdat = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : ahb

  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, idx, 32'h0, v);
    chk(nm, v, exp);
  endtask : rdchk

  // one settings write through the strobe, strobe cleared again, then compared
  task automatic tune_wr(input logic [3:0] c, input phyls_analog_t s);
    logic [31:0] v;
    ahb(1'b1, IDX_ANALOG_SET, {3'b001, s, c}, v);
    ahb(1'b1, IDX_ANALOG_SET, {3'b000, s, c}, v);
    chk("tune", {7'h0, cfg[c]}, {7'h0, s});
  endtask : tune_wr

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_clk

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // watchdog: the full sequence needs well under 1000 cycles
  initial begin
    wait_clk(5000);
    miscompares++;
    wrap_up();
  end

  initial begin
    reset_n = 1'b0; hsel = 1'b0; haddr = 12'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; pcs = '0; miscompares = 0; n_tests = 0;
    wait_clk(3);
    reset_n <= 1'b1;
    wait_clk(1);
    // reset values, reserved bits read as ones
    chk("cfg_rst", {7'h0, cfg[0]}, {7'h0, ANALOG_RST});
    chk("loop_rst", {31'h0, serial_loopback}, 32'h0);
    rdchk("lock_rst", IDX_LOCK_STAT, LOCK_RSV_100G);
    rdchk("rb_rst", IDX_ANALOG_RB, 32'h0020080);
    rdchk("up_rst", IDX_UPTIME, 32'h0);
    rdchk("sum_rst", IDX_RX_SUMMARY, 32'h0);
    rdchk("unmapped", 8'h3F, 32'h0);
    // lock layout: only three pll bits exist in this variant
    pcs.tx_pll_lock <= 4'hD; pcs.rx_cdr_lock <= 10'h2A5;
    pcs.tx_ready <= 1'b1; pcs.rx_ready <= 1'b1;
    wait_clk(3);
    rdchk("lock", IDX_LOCK_STAT, LOCK_RSV_100G | 32'h0140_0A97);
    // analog write strobe, read strobe, readback; channel 12 is out of range
    foreach (chs[i]) begin
      ch = chs[i][3:0];
      sv = 25'h1234567 + {21'h0, ch};
      ahb(1'b1, IDX_ANALOG_SET, {3'b101, sv, ch}, rd);
      wait_clk(2);
      if (chs[i] < NUM_LCH) chk("cfg", {7'h0, cfg[chs[i]]}, {7'h0, sv});
      ahb(1'b1, IDX_ANALOG_SET, {3'b100, sv, ch}, rd);
      ahb(1'b1, IDX_ANALOG_SET, {3'b110, sv, ch}, rd);
      wait_clk(2);
      rdchk("rb", IDX_ANALOG_RB, {6'h0, 1'b1, (chs[i] < NUM_LCH) ? sv : ANALOG_RST});
      rdchk("ctrl", IDX_ANALOG_SET, {3'b110, sv, ch});
      ahb(1'b1, IDX_ANALOG_SET, {3'b100, sv, ch}, rd);
      chk("loopback", {31'h0, serial_loopback}, 32'h1);
    end
    chk("cfg9_kept", {7'h0, cfg[9]}, {7'h0, 25'h1234570});
    chk("cfg1_rst", {7'h0, cfg[1]}, {7'h0, ANALOG_RST});
    // tuning order on channel 5: amplitude down, tap one up, equalizer, repeated
    tune = ANALOG_RST;
    repeat (2) begin
      tune.amplitude = tune.amplitude - 3'h1;
      tune_wr(4'h5, tune);
      tune.tap1 = tune.tap1 + 5'h1;
      tune_wr(4'h5, tune);
      tune.eq_ctrl = tune.eq_ctrl + 4'h1;
      tune_wr(4'h5, tune);
    end
    // block and marker locks, one marker missing keeps the summary low
    pcs.block_lock <= '1; pcs.marker_lock <= 20'h7FFFF;
    wait_clk(3);
    rdchk("blk", IDX_BLOCK_SYNC, 32'h000F_FFFF);
    rdchk("mrk", IDX_MARKER_LOCK, 32'h0007_FFFF);
    rdchk("sum_part", IDX_RX_SUMMARY, 32'h0);
    ahb(1'b1, IDX_BLOCK_SYNC, 32'h0, rd);
    rdchk("blk_ro", IDX_BLOCK_SYNC, 32'h000F_FFFF);
    pcs.marker_lock <= '1; pcs.lanes_deskewed <= 1'b1;
    wait_clk(3);
    rdchk("sum_dsk", IDX_RX_SUMMARY, 32'h0B);
    rdchk("sum_clr", IDX_RX_SUMMARY, 32'h03);
    pcs.mapping_chg <= 1'b1;
    wait_clk(1);
    pcs.mapping_chg <= 1'b0;
    wait_clk(2);
    rdchk("sum_map", IDX_RX_SUMMARY, 32'h13);
    rdchk("sum_map_clr", IDX_RX_SUMMARY, 32'h03);
    pcs.tag_drop_chg <= 1'b1;
    wait_clk(1);
    pcs.tag_drop_chg <= 1'b0;
    wait_clk(2);
    rdchk("sum_tag", IDX_RX_SUMMARY, 32'h07);
    rdchk("sum_tag_clr", IDX_RX_SUMMARY, 32'h03);
    // event lands at the very edge that takes the clearing read
    fork
      begin
        pcs.mapping_chg <= 1'b1;
        wait_clk(1);
        pcs.mapping_chg <= 1'b0;
      end
      begin
        wait_clk(1);
        rdchk("sum_race", IDX_RX_SUMMARY, 32'h03);
      end
    join
    rdchk("sum_kept", IDX_RX_SUMMARY, 32'h13);
    // up time: cleared when deskew drops, then ten counts per hundred cycles
    pcs.lanes_deskewed <= 1'b0;
    wait_clk(3);
    rdchk("up_drop", IDX_UPTIME, 32'h0);
    rdchk("sum_down", IDX_RX_SUMMARY, 32'h09);
    pcs.lanes_deskewed <= 1'b1;
    wait_clk(40);
    ahb(1'b0, IDX_UPTIME, 32'h0, rd);
    wait_clk(98);
    rdchk("up_rate", IDX_UPTIME, rd + 32'd10);
    wrap_up();
  end
endmodule : tb_top
